// File: rtl/tfcs_pkg.sv
// Register map, field positions and carrier types of the timer F status block.
package tfcs_pkg;
  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] TFCS_CTRL_STATUS_IDX = 8'hb7;
  localparam logic [9:0] TFCS_CTRL_STATUS_ADDR = {TFCS_CTRL_STATUS_IDX, 2'b00};
  localparam logic [7:0] TFCS_CTRL_STATUS_RST = 8'h00;
  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int TFCS_HIGH_OVF_BIT   = 7;
  localparam int TFCS_HIGH_MATCH_BIT = 6;
  localparam int TFCS_HIGH_IRQEN_BIT = 5;
  localparam int TFCS_HIGH_CLREN_BIT = 4;
  localparam int TFCS_LOW_OVF_BIT    = 3;
  localparam int TFCS_LOW_MATCH_BIT  = 2;
  localparam int TFCS_LOW_IRQEN_BIT  = 1;
  localparam int TFCS_LOW_CLREN_BIT  = 0;
  localparam logic [7:0] TFCS_FLAG_MASK = 8'hcc;

  // Events from one counter half.
  typedef struct packed {
    logic overflow;
    logic match;
  } tfcs_event_type;

  // Actions toward one counter half.
  typedef struct packed {
    logic irq;
    logic clear;
  } tfcs_action_type;
endpackage

// File: rtl/tfcs_ctrl_status.sv
// Control/status register of the paired 8-bit timer, on Avalon-MM.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
//
// Overview of operation
// RL1: Bits 7..0: high then low fields.
// RL2: Flags read, write-zero clears; enables read/write.
// RL3: Low clear enable 0 keeps counter on match.
// RL4: Low counter equal compare sets match flag.
// RL5: Match flag cleared only after read 1.
// RL6: Low wrap FF to 00 sets overflow.
// RL7: Low irq enable 0 blocks low interrupt.
// RL8: High irq enable 0 blocks high interrupt.
// RL9: Clear enable clears counter; enabled flag interrupts (here only the overflow flag interrupts).
module tfcs_ctrl_status
  import tfcs_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            arst_n,
  input  wire logic [9:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [3:0]      avs_byteenable,
  input  wire logic [31:0]     avs_writedata,
  output logic      [31:0]     avs_readdata,
  output logic                 avs_waitrequest,
  input  wire tfcs_event_type  low_event,
  input  wire tfcs_event_type  high_event,
  output tfcs_action_type      low_action,
  output tfcs_action_type      high_action
);
  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // Each access takes two cycles: waitrequest is low in the second cycle,
  // which keeps the read data registered and the outputs off flip-flops.
  logic            ack_r;
  logic            ack_nxt;
  logic [7:0]      csr_r;
  logic [7:0]      csr_nxt;
  logic [7:0]      armed_r;
  logic [7:0]      armed_nxt;
  logic [31:0]     rdata_nxt;
  logic            wait_nxt;

  wire             any_req = avs_read | avs_write;
  wire             hit     = avs_address == TFCS_CTRL_STATUS_ADDR;
  wire             req     = any_req & ~ack_r;
  wire             wr_done = avs_write & ack_r & hit & avs_byteenable[0];
  wire             rd_done = avs_read & ack_r & hit;
  wire             rd_take = req & avs_read & hit;
  wire [7:0]       wd      = avs_writedata[7:0];

  // ==========================================================================
  // Field helpers
  // ==========================================================================
  // Both halves share one nibble layout, so the low field positions
  // index a nibble of either half.

  // Places the events of one half at its flag positions.
  function automatic logic [3:0] half_set(input tfcs_event_type ev);
    half_set = 4'h0;
    half_set[TFCS_LOW_OVF_BIT]   = ev.overflow;
    half_set[TFCS_LOW_MATCH_BIT] = ev.match;
  endfunction

  // Interrupt request of one half: overflow flag set and enable set.
  function automatic logic half_irq(input logic [3:0] f);
    half_irq = f[TFCS_LOW_OVF_BIT] & f[TFCS_LOW_IRQEN_BIT];
  endfunction

  // Counter clear of one half: match while the clear enable is set.
  function automatic logic half_clr(input tfcs_event_type ev,
                                    input logic [3:0]     f);
    half_clr = ev.match & f[TFCS_LOW_CLREN_BIT];
  endfunction

  // ==========================================================================
  // Register update
  // ==========================================================================
  // Hardware set events, per bit position; set wins over a software clear.
  wire [7:0] set_vec = {half_set(high_event),
                        half_set(low_event)}; // RL4 RL6
  // A flag is cleared by writing 0 only after a completed read has armed it.
  wire [7:0] clr_vec = wr_done ? (TFCS_FLAG_MASK & ~wd & armed_r)
                               : 8'h00; // RL5
  wire [7:0] flags   = ((csr_r & ~clr_vec) | set_vec) & TFCS_FLAG_MASK; // RL2

  assign csr_nxt = wr_done ? (flags | (wd & ~TFCS_FLAG_MASK))
                           : (flags | (csr_r & ~TFCS_FLAG_MASK)); // RL1 RL2
  // Arming is set by a read that sees a flag at 1, dropped by any write to this register with byte 0 enabled.
  // Dropping it on every such write is stricter than needed, but a flag set
  // in the cycle the read is taken is armed before software has seen it.
  assign armed_nxt = wr_done ? 8'h00
                   : rd_done ? (armed_r | (csr_r & TFCS_FLAG_MASK))
                   : (armed_r & csr_r); // RL5

  assign ack_nxt = req;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      csr_r <= TFCS_CTRL_STATUS_RST;
    end else begin
      csr_r <= csr_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      armed_r <= 8'h00;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // ==========================================================================
  // Read data and handshake
  // ==========================================================================
  // Read data is loaded only when a request is taken, so it holds until
  // the next access.
  assign rdata_nxt = req ? (rd_take ? {24'h000000, csr_r} : 32'h00000000)
                         : avs_readdata; // RL2
  assign wait_nxt  = ~req;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_readdata <= 32'h00000000;
    end else begin
      avs_readdata <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= wait_nxt;
    end
  end

  // ==========================================================================
  // Counter actions
  // ==========================================================================
  // The clear pulse follows the match by one cycle so it comes off a flop.
  // Index 0 is the low half and index 1 the high half.
  tfcs_event_type  ev_arr [2];
  tfcs_action_type act_nxt [2];

  assign ev_arr[0] = low_event;
  assign ev_arr[1] = high_event;

  for (genvar g = 0; g < 2; g++) begin : g_half
    wire [3:0] next_nib = csr_nxt[4*g +: 4];
    wire [3:0] cur_nib  = csr_r[4*g +: 4];

    assign act_nxt[g].irq   = half_irq(next_nib); // RL7 RL8 RL9
    assign act_nxt[g].clear = half_clr(ev_arr[g], cur_nib); // RL3 RL9
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      low_action <= '0;
    end else begin
      low_action <= act_nxt[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      high_action <= '0;
    end else begin
      high_action <= act_nxt[1];
    end
  end
endmodule // tfcs_ctrl_status

// File: verif/tfcs_ctrl_status_props.sv
// Assertion checker for the timer F control/status register block.
`timescale 1ns/10ps
module tfcs_ctrl_status_props
  import tfcs_pkg::*;
(
  input wire logic clk_sys, arst_n, avs_read, avs_write, avs_waitrequest,
  input wire logic [9:0] avs_address,
  input wire logic [31:0] avs_readdata,
  input wire tfcs_event_type low_event,
  input wire tfcs_action_type low_action, high_action
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Properties
  // ==========================================================================
  // Enables cannot change within two cycles of a read, so the answer holds.
  sequence s_rd;
    !avs_waitrequest && avs_read && avs_address == TFCS_CTRL_STATUS_ADDR;
  endsequence
  property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("wait low twice");
  property p_up; !avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_up: assert property (p_up) else $error("upper bits set");
  property p_unm; !avs_waitrequest && avs_read
    && avs_address != TFCS_CTRL_STATUS_ADDR |-> avs_readdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_loff; s_rd ##0 !avs_readdata[1] |-> ##2 !low_action.irq; endproperty
  a_loff: assert property (p_loff) else $error("low irq masked");
  property p_hoff; s_rd ##0 !avs_readdata[5] |-> ##2 !high_action.irq;
  endproperty
  a_hoff: assert property (p_hoff) else $error("high irq masked");
  property p_lon; s_rd ##0 avs_readdata[3] && avs_readdata[1] |-> ##2
    low_action.irq; endproperty
  a_lon: assert property (p_lon) else $error("low irq missing");
  property p_hon; s_rd ##0 avs_readdata[7] && avs_readdata[5] |-> ##2
    high_action.irq; endproperty
  a_hon: assert property (p_hon) else $error("high irq missing");
  property p_lclr; s_rd ##0 !avs_readdata[0] ##2 low_event.match |=>
    !low_action.clear; endproperty
  a_lclr: assert property (p_lclr) else $error("low clear not enabled");
endmodule // tfcs_ctrl_status_props
bind tfcs_ctrl_status tfcs_ctrl_status_props u_props (.*);

// File: verif/tfcs_ctrl_status_test.sv
// Self-checking bench for the timer F control/status register block.
`timescale 1ns/10ps
module tfcs_ctrl_status_test import tfcs_pkg::*; ;
  localparam logic [9:0] AD = TFCS_CTRL_STATUS_ADDR;
  logic clk_sys = 0, arst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [3:0] avs_byteenable = 4'hf;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, exp_q[$];
  logic [15:0] rnd = 16'h17df;
  logic [1:0] act_q[$];
  tfcs_event_type low_event = 2'h0, high_event = 2'h0;
  tfcs_action_type low_action, high_action;
  int failures = 0, n_compared = 0;
  tfcs_ctrl_status uut (.*);
  initial forever #5 clk_sys = ~clk_sys;
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input logic [31:0] e, s);
    n_compared++;
    if (s !== e) failures++;
    if (s !== e) $display("ERROR readdata exp %h got %h", e, s);
  endtask
  always @(posedge clk_sys) if (avs_waitrequest === 0 && avs_read === 1)
    chk(exp_q.pop_front(), avs_readdata);
  task chk_act(input logic [1:0] e, s);
    n_compared++;
    if (s !== e) failures++;
    if (s !== e) $display("ERROR clear exp %h got %h", e, s);
  endtask
  always @(posedge clk_sys)
    if (low_action.clear === 1 || high_action.clear === 1)
      chk_act(act_q.pop_front(), {low_action.clear, high_action.clear});
  task end_sim;
    failures += exp_q.size() + act_q.size();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Random upper write bits must be ignored by the register.
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d, e);
    int n;
    n = 0;
    if (!w) exp_q.push_back({24'h0, e});
    rnd = lfsr(rnd);
    {avs_address, avs_read, avs_write} <= {a, !w, w};
    avs_writedata <= {rnd, rnd[7:0], d};
    @(posedge clk_sys);
    while (avs_waitrequest !== 0 && n++ < 20) @(posedge clk_sys);
    if (avs_waitrequest !== 0) failures++;
    {avs_read, avs_write} <= 2'b00;
    @(posedge clk_sys);
  endtask
  task ev(input tfcs_event_type lo, hi, input logic [1:0] c);
    if (c != 2'b00) act_q.push_back(c);
    {low_event, high_event} <= {lo, hi};
    @(posedge clk_sys);
    {low_event, high_event} <= 4'h0;
    @(posedge clk_sys);
  endtask
  initial begin
    #5000 failures++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1;
    repeat (3) @(posedge clk_sys);
    bus(0, AD, 0, 8'h00);
    bus(1, AD, 8'h33, 0); bus(0, AD, 0, 8'h33);
    bus(1, AD, 8'hff, 0); bus(0, AD, 0, 8'h33);
    avs_byteenable <= 4'he;
    bus(1, AD, 8'h00, 0);
    avs_byteenable <= 4'hf;
    bus(0, AD, 0, 8'h33);
    ev(2'b11, 2'b11, 2'b11); bus(0, AD, 0, 8'hff);
    bus(1, AD, 8'h33, 0); bus(0, AD, 0, 8'h33);
    $display("test flags set and cleared done");
    ev(2'b01, 2'b00, 2'b10);
    bus(1, AD, 8'h33, 0); bus(0, AD, 0, 8'h37);
    bus(1, AD, 8'h00, 0); bus(0, AD, 0, 8'h00);
    ev(2'b11, 2'b10, 2'b00); bus(0, AD, 0, 8'h8c);
    bus(0, 10'h000, 0, 8'h00);
    $display("test masked events and unmapped read done");
    end_sim;
  end
endmodule // tfcs_ctrl_status_test
